//--- logic/spdtd_regs.sv
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
`include "spdtd_params.svh"
module spdtd_regs #(
  parameter logic [7:0] ACT_TO_ACT = `SPDTD_DEF_ACT_TO_ACT,
  parameter logic [7:0] ROW_TO_COL = `SPDTD_DEF_ROW_TO_COL,
  parameter logic [7:0] ACT_TO_PRE = `SPDTD_DEF_ACT_TO_PRE,
  parameter logic [7:0] DENSITY = `SPDTD_DEF_DENSITY,
  parameter logic [7:0] CA_SETUP = `SPDTD_DEF_CA_SETUP,
  parameter logic [7:0] CA_HOLD = `SPDTD_DEF_CA_HOLD,
  parameter logic [7:0] DATA_SETUP = `SPDTD_DEF_DATA_SETUP
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic density_ok,
  output logic [2:0] time_ok
);

  // ==========================================================
  // stored bytes and their checks
  logic [7:0] rom_data;
  logic [2:0] rom_slot;
  logic [2:0] time_tenths_ok;
  logic [7:0] ca_setup_fixed;
  logic [7:0] ca_hold_fixed;
  logic [7:0] data_setup_fixed;
  logic density_nonzero;

  // density bit map: bit 0 is 4 MB, bit 7 is 512 MB; one bit per size
  assign density_nonzero = (DENSITY != 8'h00);

  // slot order matches byte order 28..34
  spdtd_rom #(
    .CONTENTS({DATA_SETUP, CA_HOLD, CA_SETUP, DENSITY, ACT_TO_PRE,
               ROW_TO_COL, ACT_TO_ACT})
  ) u_rom (
    .pclk(pclk),
    .presetn(presetn),
    .rd_slot(rom_slot),
    .rd_data(rom_data)
  );

  // sign in bit 7, ns in 6-4, tenths in 3-0
  spdtd_time_check u_ca_setup (
    .time_byte(CA_SETUP),
    .tenths_ok(time_tenths_ok[0]),
    .clamped_byte(ca_setup_fixed)
  );

  spdtd_time_check u_ca_hold (
    .time_byte(CA_HOLD),
    .tenths_ok(time_tenths_ok[1]),
    .clamped_byte(ca_hold_fixed)
  );

  spdtd_time_check u_data_setup (
    .time_byte(DATA_SETUP),
    .tenths_ok(time_tenths_ok[2]),
    .clamped_byte(data_setup_fixed)
  );

  // ==========================================================
  // address decode
  logic [7:0] reg_index;
  logic word_aligned;
  logic high_clear;
  logic hit_rom;
  logic hit_ctrl;
  logic hit_status;
  logic hit_any;
  logic setup_phase;
  logic access_phase;

  // printed offsets are indices, so drop the two byte bits
  assign reg_index = paddr[9:2];
  assign word_aligned = (paddr[1:0] == 2'b00);
  assign high_clear = (paddr[31:10] == 22'h0);
  assign hit_rom = word_aligned && high_clear &&
    (reg_index >= `SPDTD_IDX_ACT_TO_ACT_MIN) &&
    (reg_index <= `SPDTD_IDX_DATA_SETUP_TIME);
  assign hit_ctrl = word_aligned && high_clear &&
    (reg_index == `SPDTD_IDX_CTRL);
  assign hit_status = word_aligned && high_clear &&
    (reg_index == `SPDTD_IDX_STATUS);
  assign hit_any = hit_rom || hit_ctrl || hit_status;
  assign rom_slot = hit_rom ?
    3'(reg_index - `SPDTD_IDX_ACT_TO_ACT_MIN) : 3'd7;
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;

  // ==========================================================
  // sequencing state
  spdtd_pkg::spdtd_state_type state;
  spdtd_pkg::spdtd_state_type next_state;
  logic [2:0] slot_q;
  logic rom_q;
  logic ctrl_q;
  logic status_q;
  logic miss_q;
  logic wr_q;
  logic clamp_en;
  logic take_request;

  // taken only from idle, so a held setup is skipped in fetch but taken again once back in idle
  assign take_request = (state == spdtd_pkg::SPDTD_IDLE) && setup_phase;

  // one wait state: the byte store answers a cycle after setup
  always_comb begin
    next_state = state;
    case (state)
      spdtd_pkg::SPDTD_IDLE: begin
        if (setup_phase) begin
          next_state = spdtd_pkg::SPDTD_FETCH;
        end
      end
      spdtd_pkg::SPDTD_FETCH: begin
        // a master that gives up after setup gets no answer
        if (access_phase) begin
          next_state = spdtd_pkg::SPDTD_DONE;
        end else begin
          next_state = spdtd_pkg::SPDTD_IDLE;
        end
      end
      spdtd_pkg::SPDTD_DONE: begin
        next_state = spdtd_pkg::SPDTD_IDLE;
      end
      default: begin
        next_state = spdtd_pkg::SPDTD_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= spdtd_pkg::SPDTD_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // slot and direction latched at setup; the master holds them anyway
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_q <= 3'd0;
      rom_q <= 1'b0;
      wr_q <= 1'b0;
    end else if (take_request) begin
      slot_q <= rom_slot;
      rom_q <= hit_rom;
      wr_q <= pwrite;
    end
  end

  // register class of the request, kept for the answer edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 1'b0;
      status_q <= 1'b0;
      miss_q <= 1'b0;
    end else if (take_request) begin
      ctrl_q <= hit_ctrl;
      status_q <= hit_status;
      miss_q <= !hit_any;
    end
  end

  // ==========================================================
  // read data selection
  logic sel_ca_setup;
  logic sel_ca_hold;
  logic sel_data_setup;
  logic [7:0] time_fixed;
  logic slot_bad;
  logic [7:0] rom_view;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [31:0] next_rdata;
  logic miss_err;
  logic ro_write_err;
  logic next_err;
  logic answer_now;

  // slots of the signed time bytes, counted from the first stored byte
  assign sel_ca_setup = (slot_q == 3'(`SPDTD_IDX_CMD_ADDR_SETUP_TIME -
    `SPDTD_IDX_ACT_TO_ACT_MIN));
  assign sel_ca_hold = (slot_q == 3'(`SPDTD_IDX_CMD_ADDR_HOLD_TIME -
    `SPDTD_IDX_ACT_TO_ACT_MIN));
  assign sel_data_setup = (slot_q == 3'(`SPDTD_IDX_DATA_SETUP_TIME -
    `SPDTD_IDX_ACT_TO_ACT_MIN));
  // one-hot and-or, so no index can run past the three flags
  assign time_fixed = ({8{sel_ca_setup}} & ca_setup_fixed) |
    ({8{sel_ca_hold}} & ca_hold_fixed) |
    ({8{sel_data_setup}} & data_setup_fixed);
  assign slot_bad = (sel_ca_setup && !time_tenths_ok[0]) ||
    (sel_ca_hold && !time_tenths_ok[1]) ||
    (sel_data_setup && !time_tenths_ok[2]);

  // clamping trades exactness for never showing a reserved code
  assign rom_view = (clamp_en && slot_bad) ? time_fixed : rom_data;

  // field positions kept in the header, so the map lives in one place
  assign ctrl_word = 32'(clamp_en) << `SPDTD_CTRL_CLAMP_BIT;
  assign status_word = (32'(density_ok) << `SPDTD_STAT_DENSITY_OK_BIT) |
    (32'(time_ok) << `SPDTD_STAT_TIME_OK_LO);
  assign next_rdata = (rom_q && !wr_q) ? {24'h0, rom_view} :
    (ctrl_q && !wr_q) ? ctrl_word :
    (status_q && !wr_q) ? status_word : 32'h0;

  // unmapped addresses and writes to read-only bytes are refused
  assign miss_err = miss_q;
  assign ro_write_err = wr_q && !ctrl_q;
  assign next_err = miss_err || ro_write_err;

  // answer only while the access phase is really there
  assign answer_now = (state == spdtd_pkg::SPDTD_FETCH) && access_phase;

  // ready is a one-cycle pulse per transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= answer_now;
    end
  end

  // read data stand only with ready, zero otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (answer_now) begin
      prdata <= next_rdata;
    end else begin
      prdata <= 32'h0;
    end
  end

  // error flag qualified by ready like the data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= answer_now && next_err;
    end
  end

  // ==========================================================
  // control register, written on the completing edge only
  logic ctrl_write;

  // without the low byte strobe a write leaves the bit alone
  assign ctrl_write = (state == spdtd_pkg::SPDTD_DONE) && access_phase &&
    ctrl_q && wr_q && pstrb[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clamp_en <= 1'(`SPDTD_CTRL_RESET);
    end else if (ctrl_write) begin
      clamp_en <= pwdata[`SPDTD_CTRL_CLAMP_BIT];
    end
  end

  // ==========================================================
  // health flags of the stored contents, refreshed every cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      density_ok <= 1'b0;
    end else begin
      density_ok <= density_nonzero;
    end
  end

  // one time flag per signed byte, in byte order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      time_ok <= 3'b000;
    end else begin
      time_ok <= time_tenths_ok;
    end
  end

endmodule : spdtd_regs

//--- logic/spdtd_params.svh
`ifndef SPDTD_PARAMS_SVH
`define SPDTD_PARAMS_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define SPDTD_IDX_ACT_TO_ACT_MIN 8'h1C
`define SPDTD_IDX_ROW_TO_COL_DELAY_MIN 8'h1D
`define SPDTD_IDX_ACT_TO_PRECHARGE_MIN 8'h1E
`define SPDTD_IDX_ROW_DENSITY_MAP 8'h1F
`define SPDTD_IDX_CMD_ADDR_SETUP_TIME 8'h20
`define SPDTD_IDX_CMD_ADDR_HOLD_TIME 8'h21
`define SPDTD_IDX_DATA_SETUP_TIME 8'h22
`define SPDTD_IDX_CTRL 8'h30
`define SPDTD_IDX_STATUS 8'h31

// ==========================================================
// field positions of a signed time byte
`define SPDTD_TIME_SIGN_BIT 7
`define SPDTD_TIME_NS_HI 6
`define SPDTD_TIME_NS_LO 4
`define SPDTD_TIME_TENTHS_HI 3
`define SPDTD_TIME_TENTHS_LO 0
`define SPDTD_TENTHS_MAX 4'h9

// ==========================================================
// control and status fields
`define SPDTD_CTRL_CLAMP_BIT 0
`define SPDTD_CTRL_RESET 32'h0000_0000
`define SPDTD_STAT_DENSITY_OK_BIT 0
`define SPDTD_STAT_TIME_OK_LO 1

// ==========================================================
// default stored contents (plain values, overridable)
`define SPDTD_DEF_ACT_TO_ACT 8'h14
`define SPDTD_DEF_ROW_TO_COL 8'h14
`define SPDTD_DEF_ACT_TO_PRE 8'h2D
`define SPDTD_DEF_DENSITY 8'h08
`define SPDTD_DEF_CA_SETUP 8'h25
`define SPDTD_DEF_CA_HOLD 8'h85
`define SPDTD_DEF_DATA_SETUP 8'h25

`endif

//--- logic/spdtd_pkg.sv
package spdtd_pkg;

  // ==========================================================
  // apb slave sequencing
  typedef enum logic [1:0] {
    SPDTD_IDLE = 2'b00,
    SPDTD_FETCH = 2'b01,
    SPDTD_DONE = 2'b10
  } spdtd_state_type;

endpackage : spdtd_pkg

//--- logic/spdtd_rom.sv
`timescale 1ns/10ps
// ==========================================================
// seven stored bytes, registered read data
module spdtd_rom #(
  parameter logic [55:0] CONTENTS = 56'h0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] rd_slot,
  output logic [7:0] rd_data
);

  logic [7:0] slot_byte;

  // slot 0 sits in the low byte; unused slot reads zero
  assign slot_byte = (rd_slot < 3'd7) ? CONTENTS[rd_slot * 8 +: 8] : 8'h00;

  // registered read port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= slot_byte;
    end
  end

endmodule : spdtd_rom

//--- logic/spdtd_time_check.sv
`timescale 1ns/10ps
`include "spdtd_params.svh"
// ==========================================================
// checks one sign-magnitude time byte
module spdtd_time_check (
  input wire logic [7:0] time_byte,
  output logic tenths_ok,
  output logic [7:0] clamped_byte
);

  logic [3:0] tenths;

  // tenths codes above nine are reserved; clamp keeps sign and ns
  assign tenths = time_byte[`SPDTD_TIME_TENTHS_HI:`SPDTD_TIME_TENTHS_LO];
  assign tenths_ok = (tenths <= `SPDTD_TENTHS_MAX);
  assign clamped_byte = tenths_ok ? time_byte :
    {time_byte[`SPDTD_TIME_SIGN_BIT:`SPDTD_TIME_NS_LO], `SPDTD_TENTHS_MAX};

endmodule : spdtd_time_check

//--- sim/spdtd_regs_properties.sv
`timescale 1ns/10ps
// ==========================================================
// port checks of the timing and density slave
module spdtd_regs_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic density_ok,
  input wire logic [2:0] time_ok
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a completed read without error
  wire logic rd_ok = pready && !pwrite && !pslverr;
  sequence s_wait_ready;
    !pready ##1 pready;
  endsequence
  property p_one_wait;
    psel && !penable |=> s_wait_ready;
  endproperty
  property p_pulse;
    pready |=> !pready;
  endproperty
  property p_idle_zero;
    !pready |-> prdata == 32'h0;
  endproperty
  property p_byte_only;
    pready |-> prdata[31:8] == 24'h0;
  endproperty
  property p_density;
    rd_ok && paddr == 32'h7C |-> (prdata[7:0] != 8'h00) == density_ok;
  endproperty
  property p_ca_setup;
    rd_ok && paddr == 32'h80 && time_ok[0] |-> prdata[3:0] <= 4'h9;
  endproperty
  property p_data_setup;
    rd_ok && paddr == 32'h88 && prdata[3:0] > 4'h9 |-> !time_ok[2];
  endproperty
  property p_ro_write;
    pready && pwrite && paddr >= 32'h70 && paddr <= 32'h88 |-> pslverr;
  endproperty
  property p_stray;
    pready && paddr[1:0] != 2'b00 |-> pslverr && prdata == 32'h0;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("late answer");
  a_pulse: assert property (p_pulse) else $error("ready too long");
  a_idle_zero: assert property (p_idle_zero) else $error("stray data");
  a_byte_only: assert property (p_byte_only) else $error("upper bits");
  a_density: assert property (p_density) else $error("density flag");
  a_ca_setup: assert property (p_ca_setup) else $error("setup tenths");
  a_data_setup: assert property (p_data_setup) else $error("tenths");
  a_ro_write: assert property (p_ro_write) else $error("write taken");
  a_stray: assert property (p_stray) else $error("misaligned taken");
endmodule : spdtd_regs_checker

bind spdtd_regs spdtd_regs_checker u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .density_ok(density_ok), .time_ok(time_ok));

//--- sim/spdtd_host_decode.sv
`timescale 1ns/10ps
// ==========================================================
// host-side reader of one signed setup or hold byte
module spdtd_host_decode (
  input wire logic [7:0] time_byte,
  output logic negative,
  output logic [2:0] whole_ns,
  output logic [3:0] tenths,
  output logic usable
);
  // sign on top, set means before the edge
  assign negative = time_byte[7];
  // whole ns and tenths are summed, never mixed
  assign whole_ns = time_byte[6:4];
  assign tenths = time_byte[3:0];
  // codes past nine are never turned into a time
  assign usable = time_byte[3:0] <= 4'h9;
endmodule : spdtd_host_decode

//--- sim/test_spd_timing_density_fields.sv
`timescale 1ns/10ps
// ==========================================================
// bench for the timing and density slave
module test_spd_timing_density_fields;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic density_ok;
  logic [2:0] time_ok;
  logic [7:0] dec_in = 8'h00;
  wire logic [8:0] dec_out;
  logic [31:0] rd;
  logic er;
  int fail_count = 0;
  int checked = 0;
  // edge contents, three bytes at defaults; last has reserved tenths
  logic [7:0] eb [7] = '{8'hFF, 8'h14, 8'h2D, 8'h0C, 8'h79, 8'h85, 8'hFA};
  logic [8:0] de [3] = '{9'h0F3, 9'h10B, 9'h1F4};

  always #2 pclk = ~pclk;

  spdtd_regs #(.ACT_TO_ACT(8'hFF), .DENSITY(8'h0C), .CA_SETUP(8'h79),
    .CA_HOLD(8'h85), .DATA_SETUP(8'hFA)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .density_ok(density_ok), .time_ok(time_ok));
  spdtd_host_decode host (.time_byte(dec_in), .negative(dec_out[8]),
    .whole_ns(dec_out[7:5]), .tenths(dec_out[4:1]), .usable(dec_out[0]));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      fail_count++;
    end
  endtask : chk

  // one transfer plus an idle cycle, so no signal is set twice at an edge
  task xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20) fail_count++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task rd_chk(input logic [31:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0, 4'h0);
    chk(rd, e);
    chk({31'h0, er}, 32'h0);
  endtask : rd_chk

  task final_report;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 7; i++) begin
      rd_chk(32'h70 + 32'(i) * 4, {24'h0, eb[i]});
    end
    chk({31'h0, density_ok}, 32'h1);
    chk({29'h0, time_ok}, 32'h3);
    rd_chk(32'hC4, 32'h7);
    for (int i = 0; i < 3; i++) begin
      xfer(32'h80 + 32'(i) * 4, 1'b0, 32'h0, 4'h0);
      dec_in <= rd[7:0];
      @(posedge pclk);
      chk({23'h0, dec_out}, {23'h0, de[i]});
    end
    $display("test contents done");
    // refused: write to a byte, misaligned and unmapped reads
    xfer(32'h70, 1'b1, 32'h0, 4'hF);
    chk({31'h0, er}, 32'h1);
    xfer(32'h71, 1'b0, 32'h0, 4'h0);
    chk({31'h0, er}, 32'h1);
    xfer(32'h8C, 1'b0, 32'h0, 4'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    xfer(32'hC4, 1'b1, 32'h0, 4'hF);
    chk({31'h0, er}, 32'h1);
    rd_chk(32'h70, 32'hFF);
    // clamp needs the low strobe; it must spare legal bytes
    xfer(32'hC0, 1'b1, 32'h1, 4'h0);
    chk({31'h0, er}, 32'h0);
    rd_chk(32'h88, 32'hFA);
    xfer(32'hC0, 1'b1, 32'h1, 4'h1);
    rd_chk(32'hC0, 32'h1);
    rd_chk(32'h88, 32'hF9);
    rd_chk(32'h80, 32'h79);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(32'h88, 32'hFA);
    $display("test refusals done");
    final_report;
  end

  // watchdog well past the expected run
  initial begin
    #4000;
    fail_count++;
    final_report;
  end
endmodule : test_spd_timing_density_fields
